// [src/lpts_seq.sv]
// Pulse template sequencer with Wishbone register slave
//
// Chosen here: register access over Wishbone.
module lpts_seq
  import lpts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic pulse_pos_i,
  input wire logic pulse_neg_i,
  output logic transmit_clock_out_o,
  output logic [3:0] dac_code_o,
  output logic line_out_pos_drive_o,
  output logic line_out_neg_drive_o,
  output logic line_out_pos_ground_o,
  output logic line_out_neg_ground_o
);
  import lpts_pkg::*;

  // Software visible registers
  logic [7:0] line_length_config;
  logic [7:0] pulse_config;
  logic [7:0] template_code_index;

  // Sequencer state
  logic [2:0] slot;
  logic [2:0] next_slot;
  logic pos_q;
  logic neg_q;
  lpts_src_t src_q;
  lpts_src_t next_src;
  logic [2:0] row_q;
  logic [2:0] out_slot;

  // Bus decode
  logic [5:0] idx;
  logic req;
  logic wr_take;
  logic rd_start;
  logic lane0;
  logic [7:0] rd_byte;

  // Code paths
  logic [3:0] seq_code;
  logic [3:0] bus_code;
  logic [3:0] rom_code;
  logic [3:0] cur_code;
  logic [3:0] next_code;
  logic pulse_on;
  logic body;
  logic next_pos_drive;
  logic next_neg_drive;
  logic custom_template_enable;
  logic template_select_flag;
  logic tx_unipolar_select;
  logic [2:0] line_length_field;
  logic code_we;

  // Field views of the registers
  assign custom_template_enable = pulse_config[CFG_CUST_BIT];
  assign tx_unipolar_select = pulse_config[CFG_UNI_BIT];
  assign template_select_flag = line_length_config[LL_SEL_BIT];
  assign line_length_field = line_length_config[LL_FIELD_LSB +: 3];

  // Wishbone decode; registers live in the low byte lane only
  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i & wb_stb_i;
  assign lane0 = wb_sel_i[0];
  assign rd_start = req & ~wb_ack_o & ~wb_we_i;
  // A write lands on the edge where the master sees ack
  assign wr_take = req & wb_ack_o & wb_we_i & lane0;
  assign code_we = wr_take & (idx == IDX_CODE_DATA);

  // One wait state: ack follows the request by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // Register writes; unmapped indices are acked and ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_length_config <= LL_RST;
      pulse_config <= CFG_RST;
      template_code_index <= INDEX_RST;
    end else if (wr_take) begin
      case (idx)
        IDX_LINE_LEN: begin
          line_length_config <= wb_dat_i[7:0];
        end
        IDX_CFG: begin
          pulse_config <= {6'h00, wb_dat_i[1:0]};
        end
        IDX_CODE_INDEX: begin
          template_code_index <= wb_dat_i[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; data register returns the slot picked by index
  assign rd_byte =
    (idx == IDX_LINE_LEN) ? line_length_config :
    (idx == IDX_CFG) ? pulse_config :
    (idx == IDX_CODE_INDEX) ? template_code_index :
    (idx == IDX_CODE_DATA) ? {4'h0, bus_code} :
    (idx == IDX_STATUS) ? {2'b00, src_q, pulse_on, slot} :
    8'h00;

  // Read data is captured as ack rises and held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_start) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Code slots; the sequencer reads one slot ahead so that the
  // registered read lines up with the slot counter
  lpts_code_mem #(
    .DEPTH(SLOTS),
    .WIDTH(CODE_W),
    .AW(SLOT_W)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(code_we),
    .waddr_i(template_code_index[2:0]),
    .wdata_i(wb_dat_i[3:0]),
    .raddr_a_i(next_slot),
    .rdata_a_o(seq_code),
    .raddr_b_i(template_code_index[2:0]),
    .rdata_b_o(bus_code)
  );

  // Built-in templates indexed by the latched length range
  lpts_template_rom u_rom (
    .row_i(row_q),
    .slot_i(slot),
    .code_o(rom_code)
  );

  // Free-running slot counter: eight fast periods per transmit cycle
  assign next_slot = slot + 3'd1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot <= 3'd0;
    end else begin
      slot <= next_slot;
    end
  end

  // Source choice; unipolar mode leaves the shaper idle
  assign next_src = tx_unipolar_select ? SRC_IDLE :
                    custom_template_enable ? SRC_CUSTOM :
                    template_select_flag ? SRC_ROM : SRC_IDLE;

  // Pulse polarity, source and row are latched at the cycle
  // boundary so a mid-cycle length or config write never tears a pulse in half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      src_q <= SRC_IDLE;
      row_q <= 3'd0;
    end else if (slot == 3'(SLOTS - 1)) begin
      pos_q <= pulse_pos_i & ~pulse_neg_i;
      neg_q <= pulse_neg_i & ~pulse_pos_i;
      src_q <= next_src;
      row_q <= line_length_field;
    end
  end

  // Code and steering for the current slot
  assign pulse_on = (pos_q | neg_q) & (src_q != SRC_IDLE);
  assign body = lpts_is_body(slot);
  assign cur_code = (src_q == SRC_CUSTOM) ? seq_code :
                    (src_q == SRC_ROM) ? rom_code : 4'h0;
  assign next_code = pulse_on ? cur_code : 4'h0;
  // Body on the pulse's own rail, tail on the other
  assign next_pos_drive = pulse_on & (body ? pos_q : neg_q);
  assign next_neg_drive = pulse_on & (body ? neg_q : pos_q);

  // Output stage; the transmit clock is low during the body slots
  // so slot 0 is applied on the edge that takes it low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_clock_out_o <= 1'b1;
      dac_code_o <= 4'h0;
      line_out_pos_drive_o <= 1'b0;
      line_out_neg_drive_o <= 1'b0;
      line_out_pos_ground_o <= 1'b1;
      line_out_neg_ground_o <= 1'b1;
      out_slot <= 3'd0;
    end else begin
      transmit_clock_out_o <= ~body;
      dac_code_o <= next_code;
      line_out_pos_drive_o <= next_pos_drive;
      line_out_neg_drive_o <= next_neg_drive;
      line_out_pos_ground_o <= ~next_pos_drive;
      line_out_neg_ground_o <= ~next_neg_drive;
      out_slot <= slot;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_slot_wrap;
    slot == 3'd7 |=> slot == 3'd0;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap)
    else $error("slot counter did not wrap to zero");

  property p_tclk_slot0;
    $fell(transmit_clock_out_o) |-> out_slot == 3'd0;
  endproperty
  a_tclk_slot0: assert property (p_tclk_slot0)
    else $error("transmit clock fell away from slot 0");

  sequence s_pos_body;
    (line_out_pos_drive_o && !line_out_neg_drive_o)[*4];
  endsequence
  sequence s_neg_tail;
    (line_out_neg_drive_o && !line_out_pos_drive_o)[*4];
  endsequence
  property p_pos_pulse;
    (pulse_on && pos_q && slot == 3'd0) |=>
      s_pos_body ##1 s_neg_tail;
  endproperty
  a_pos_pulse: assert property (p_pos_pulse)
    else $error("positive pulse body or tail misrouted");

  property p_ground;
    line_out_pos_drive_o |->
      line_out_neg_ground_o && !line_out_pos_ground_o;
  endproperty
  a_ground: assert property (p_ground)
    else $error("idle rail not grounded while other drives");

  property p_idle;
    !pulse_on |=> dac_code_o == 4'h0 &&
      line_out_pos_ground_o && line_out_neg_ground_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle cycle did not send code zero");

  property p_rom_short;
    (src_q == SRC_ROM && row_q == 3'd0 && pulse_on &&
      slot == 3'd0) |=> dac_code_o == SHORT_SLOT0;
  endproperty
  a_rom_short: assert property (p_rom_short)
    else $error("short template slot 0 code wrong");

  property p_custom;
    (src_q == SRC_CUSTOM && pulse_on) |=>
      dac_code_o == $past(seq_code);
  endproperty
  a_custom: assert property (p_custom)
    else $error("custom code not applied");

  property p_ack;
    (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not one cycle after request");

  property p_readback;
    (rd_start && idx == IDX_CODE_DATA) |=>
      wb_dat_o == {28'h000_0000, $past(bus_code)};
  endproperty
  a_readback: assert property (p_readback)
    else $error("code readback mismatch");

  // Negative pulse: body on the negative rail, tail on the positive
  sequence s_neg_body;
    (line_out_neg_drive_o && !line_out_pos_drive_o)[*4];
  endsequence
  sequence s_pos_tail;
    (line_out_pos_drive_o && !line_out_neg_drive_o)[*4];
  endsequence
  property p_neg_pulse;
    (pulse_on && neg_q && slot == 3'd0) |=>
      s_neg_body ##1 s_pos_tail;
  endproperty
  a_neg_pulse: assert property (p_neg_pulse)
    else $error("negative pulse body or tail misrouted");

  // Transmit clock low for output slots 0-3, high for 4-7; the first
  // edge after reset still shows reset values, so it is skipped
  property p_tclk_period;
    !$past(rst_i) |-> transmit_clock_out_o == (out_slot > 3'd3);
  endproperty
  a_tclk_period: assert property (p_tclk_period)
    else $error("transmit clock phase does not follow the slot");

  // Mirror of the grounding check for the negative rail
  property p_ground_neg;
    line_out_neg_drive_o |->
      line_out_pos_ground_o && !line_out_neg_ground_o;
  endproperty
  a_ground_neg: assert property (p_ground_neg)
    else $error("positive rail not grounded while negative drives");

  // Both pulse inputs high at the boundary means no pulse this cycle
  property p_both_idle;
    (slot == 3'd7 && pulse_pos_i && pulse_neg_i) |=> !pulse_on;
  endproperty
  a_both_idle: assert property (p_both_idle)
    else $error("pulse sent although both inputs were high");

  // Unipolar mode must leave the shaper idle at the next boundary
  property p_unipolar_idle;
    (slot == 3'd7 && tx_unipolar_select) |=> src_q == SRC_IDLE;
  endproperty
  a_unipolar_idle: assert property (p_unipolar_idle)
    else $error("shaper active in unipolar mode");

  // Source and row only move at the boundary, never mid-pulse
  property p_src_hold;
    slot != 3'd7 |=> $stable(src_q) && $stable(row_q);
  endproperty
  a_src_hold: assert property (p_src_hold)
    else $error("template source changed inside a transmit cycle");

  // The length field is latched as the row at each boundary
  property p_row_latch;
    slot == 3'd7 |=> row_q == $past(line_length_field);
  endproperty
  a_row_latch: assert property (p_row_latch)
    else $error("template row not taken from the length field");

  // A stored code reaches the readback port two edges after the write
  property p_code_store;
    code_we |-> ##2 bus_code == $past(wb_dat_i[3:0], 2);
  endproperty
  a_code_store: assert property (p_code_store)
    else $error("code slot did not keep the written value");

endmodule

// [src/lpts_pkg.sv]
// Shared constants and types for the line pulse template sequencer
//
// Overview of operation
// - Eight writable 4-bit amplitude code slots
// - Slots reached through index and data registers
// - Slot 0 first after transmit clock falls
// - Slots 0-3 body, slots 4-7 opposite tail
// - Idle output grounded while other drives
// - Higher code gives larger monotonic amplitude
// - Seven built-in templates chosen by length
// - Flag 1, length 000 picks short template
// - Setting enable switches pulses to loaded codes
// - Slots read back through index and data
package lpts_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SLOTS = 8;
  localparam int unsigned BODY_SLOTS = 4;
  localparam int unsigned SLOT_W = 3;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned ROWS = 7;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_LINE_LEN = 6'h14;
  localparam logic [5:0] IDX_CFG = 6'h15;
  localparam logic [5:0] IDX_CODE_INDEX = 6'h16;
  localparam logic [5:0] IDX_CODE_DATA = 6'h17;
  localparam logic [5:0] IDX_STATUS = 6'h18;

  // Field positions
  localparam int unsigned LL_SEL_BIT = 6;
  localparam int unsigned LL_FIELD_LSB = 0;
  localparam int unsigned CFG_CUST_BIT = 0;
  localparam int unsigned CFG_UNI_BIT = 1;

  // Values after reset, and the short template's slot 0 code
  localparam logic [7:0] LL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [3:0] SHORT_SLOT0 = 4'hb;

  // Template source for one transmit clock cycle
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_ROM = 2'b01,
    SRC_CUSTOM = 2'b10
  } lpts_src_t;

  // Slots 0..3 form the pulse body, 4..7 the tail
  function automatic logic lpts_is_body(input logic [2:0] slot);
    lpts_is_body = (slot < 3'(BODY_SLOTS));
  endfunction

endpackage

// [src/lpts_code_mem.sv]
// Writable code slot memory with two registered read ports
module lpts_code_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 4,
  parameter int unsigned AW = 3
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [WIDTH-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [WIDTH-1:0] rdata_b_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Port a feeds the sequencer, port b the bus readback
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
  end
endmodule

// [src/lpts_template_rom.sv]
// Built-in pulse templates, one row per line length range
module lpts_template_rom
  import lpts_pkg::*;
(
  input wire logic [2:0] row_i,
  input wire logic [2:0] slot_i,
  output logic [3:0] code_o
);
  import lpts_pkg::*;

  // Slot 0 sits in the low nibble of each row
  localparam logic [31:0] TBL [ROWS] = '{
    32'h1233_aaab,
    32'h1234_aabc,
    32'h1245_bbce,
    32'h1356_bbde,
    32'h1358_bbef,
    32'h1358_abcf,
    32'h135a_aacf
  };

  logic [2:0] row;

  // Unused length code 7 falls back to the longest range
  assign row = (row_i > 3'(ROWS - 1)) ? 3'(ROWS - 1) : row_i;
  assign code_o = TBL[row][{slot_i, 2'b00} +: 4];
endmodule

// [verif/lpts_line_model.sv]
// Line transformer model seen across the two driven outputs
module lpts_line_model (
  input wire logic [3:0] code_i,
  input wire logic pos_drive_i,
  input wire logic neg_drive_i,
  output logic signed [5:0] level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Positive rail minus negative rail; larger code, larger swing
  assign level_o = pos_drive_i ? $signed({2'b00, code_i}) :
    neg_drive_i ? -$signed({2'b00, code_i}) : 6'sh00;
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the pulse template sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic pulse_pos_i = 1'b0;
  logic pulse_neg_i = 1'b0;
  logic tclk;
  logic [3:0] code;
  wire [3:0] rails;
  logic signed [5:0] level;
  int fails = 0;
  int comparisons = 0;
  logic [3:0] rom0 [8] = '{4'hb, 4'ha, 4'ha, 4'ha, 4'h3, 4'h3, 4'h2, 4'h1};
  logic [3:0] rom6 [8] = '{4'hf, 4'hc, 4'ha, 4'ha, 4'ha, 4'h5, 4'h3, 4'h1};

  // Half period of a 50 ns clock
  always #25 clk_i = ~clk_i;

  lpts_seq lpts_seq_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pulse_pos_i(pulse_pos_i),
    .pulse_neg_i(pulse_neg_i), .transmit_clock_out_o(tclk),
    .dac_code_o(code), .line_out_pos_drive_o(rails[3]),
    .line_out_neg_drive_o(rails[2]), .line_out_pos_ground_o(rails[1]),
    .line_out_neg_ground_o(rails[0])
  );

  lpts_line_model lpts_line_model_inst (
    .code_i(code), .pos_drive_i(rails[3]), .neg_drive_i(rails[2]),
    .level_o(level)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One classic cycle; starts just after an edge, so the gap is kept
  task automatic wb(input logic we, input logic [7:0] adr,
      input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      results();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Skips one boundary so config changes land, then judges 8 slots
  task automatic pulse_check(input logic [3:0] exp [8], input logic neg,
      input logic idle);
    int n;
    logic prev;
    logic p;
    logic [5:0] lv;
    logic [31:0] e;
    n = 0;
    repeat (2) begin
      do begin
        prev = tclk;
        @(negedge clk_i);
        n++;
      end while (!(prev === 1'b1 && tclk === 1'b0) && n < 40);
    end
    if (n >= 40) begin
      fails++;
      results();
    end
    for (int k = 0; k < 8; k++) begin
      p = (k < 4) ^ neg;
      lv = idle ? 6'h00 : (p ? {2'b00, exp[k]} : -{2'b00, exp[k]});
      e = {21'h0, k > 3, idle ? 4'b0011 : {p, !p, !p, p}, lv};
      check({21'h0, tclk, rails, level}, e);
      @(negedge clk_i);
    end
  endtask

  task automatic set_pulse(input logic pos, input logic neg);
    @(posedge clk_i);
    pulse_pos_i <= pos;
    pulse_neg_i <= neg;
  endtask

  // Registers come up clear and no template is active
  task automatic t_reset_idle();
    logic [31:0] q;
    for (int a = 8'h50; a <= 8'h58; a += 4) begin
      wb(1'b0, 8'(a), 8'h00, q);
      check(q, 32'h0);
    end
    set_pulse(1'b1, 1'b0);
    pulse_check(rom0, 1'b0, 1'b1);
  endtask

  // Short-range built-in template, positive then negative back to back
  task automatic t_rom_short();
    logic [31:0] q;
    wb(1'b1, 8'h50, 8'h40, q);
    pulse_check(rom0, 1'b0, 1'b0);
    set_pulse(1'b0, 1'b1);
    pulse_check(rom0, 1'b1, 1'b0);
    // Unused length code 7 falls back to the longest-range row
    wb(1'b1, 8'h50, 8'h47, q);
    pulse_check(rom6, 1'b1, 1'b0);
  endtask

  // Load, read back and enable a custom code set spanning 1 to f
  task automatic t_custom();
    logic [31:0] q;
    logic [3:0] cust [8];
    wb(1'b1, 8'h54, 8'h00, q);
    for (int i = 0; i < 8; i++) begin
      cust[i] = 4'(2 * i + 1);
      wb(1'b1, 8'h58, 8'(i), q);
      wb(1'b1, 8'h5c, {4'h0, cust[i]}, q);
    end
    for (int i = 7; i >= 0; i--) begin
      wb(1'b1, 8'h58, 8'(i), q);
      wb(1'b0, 8'h5c, 8'h00, q);
      check(q, {28'h0, cust[i]});
    end
    wb(1'b1, 8'h54, 8'h01, q);
    pulse_check(cust, 1'b1, 1'b0);
    // Status shows custom source with a pulse active; slot bits vary
    wb(1'b0, 8'h60, 8'h00, q);
    check(q & 32'hffff_fff8, 32'h0000_0028);
    set_pulse(1'b1, 1'b1);
    pulse_check(cust, 1'b0, 1'b1);
    // Unipolar mode keeps the shaper idle even with a pulse requested
    set_pulse(1'b1, 1'b0);
    wb(1'b1, 8'h54, 8'h03, q);
    pulse_check(cust, 1'b0, 1'b1);
  endtask

  // Unmapped place reads zero and drops writes
  task automatic t_unmapped();
    logic [31:0] q;
    wb(1'b1, 8'hfc, 8'hff, q);
    wb(1'b0, 8'hfc, 8'h00, q);
    check(q, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_idle();
    t_rom_short();
    t_custom();
    t_unmapped();
    results();
  end
endmodule
